// ### hdl/qrm_engine.sv
// Locked queue removal engine with an AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module qrm_engine
  import qrm_pkg::*;
(
  // Clock and reset
  input  wire logic               i_core_clk,
  input  wire logic               i_nrst,
  // AXI4-Lite slave
  input  wire logic               i_s_axi_awvalid,
  output logic                    o_s_axi_awready,
  input  wire logic [QRM_AW-1:0]  i_s_axi_awaddr,
  input  wire logic               i_s_axi_wvalid,
  output logic                    o_s_axi_wready,
  input  wire logic [31:0]        i_s_axi_wdata,
  input  wire logic [3:0]         i_s_axi_wstrb,
  output logic                    o_s_axi_bvalid,
  input  wire logic               i_s_axi_bready,
  output logic [1:0]              o_s_axi_bresp,
  input  wire logic               i_s_axi_arvalid,
  output logic                    o_s_axi_arready,
  input  wire logic [QRM_AW-1:0]  i_s_axi_araddr,
  output logic                    o_s_axi_rvalid,
  input  wire logic               i_s_axi_rready,
  output logic [31:0]             o_s_axi_rdata,
  output logic [1:0]              o_s_axi_rresp,
  // Shared memory port
  output qrm_mem_req_t            o_mem,
  input  wire logic               i_mem_ack,
  input  wire logic [31:0]        i_mem_rdata,
  input  wire logic               i_mem_deny,
  // Processor side
  output logic                    o_intr_hold,
  output logic                    o_irq
);

  qrm_state_t           st_reg, st_next;
  qrm_mem_req_t         req_next;
  qrm_cc_t              cc_reg;
  logic [31:0]          hdr_reg, dst_reg, tmp_reg, blink_reg, link_reg, result_reg;
  logic [31:0]          ent, nbr, new_link;
  logic                 tail_reg, rsvd_reg, mmf_reg, set_rsvd, set_mmf, start;
  logic [QRM_IRQ_W-1:0] irq_st_reg, irq_msk_reg, irq_ev;
  logic [QRM_AW-1:0]    awaddr_reg;
  logic [31:0]          wdata_reg;
  logic                 aw_held, w_held, wr_fire;
  logic [7:0]           wr_opc;

  // Entry under removal and its neighbour on the far side
  assign ent      = tail_reg ? hdr_reg + blink_reg : hdr_reg + tmp_reg;
  assign nbr      = ent + link_reg;
  assign new_link = tail_reg ? blink_reg + link_reg : tmp_reg + link_reg;

  // Write channel capture; address and data may come in either order
  assign wr_fire = aw_held && w_held && !o_s_axi_bvalid;
  assign wr_opc  = wdata_reg[QRM_OPC_LSB +: 8];
  assign start   = wr_fire && awaddr_reg == QRM_OFS_CTRL && wdata_reg[QRM_CTRL_GO]
                   && (wr_opc == QRM_OPC_HEAD || wr_opc == QRM_OPC_TAIL) && st_reg == QRM_IDLE;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      awaddr_reg      <= '0;
      wdata_reg       <= QRM_ZERO;
      o_s_axi_awready <= 1'b1;
      o_s_axi_wready  <= 1'b1;
      o_s_axi_bvalid  <= 1'b0;
      o_s_axi_bresp   <= QRM_RESP_OKAY;
    end else begin
      if (i_s_axi_awvalid && o_s_axi_awready) begin
        aw_held         <= 1'b1;
        awaddr_reg      <= i_s_axi_awaddr;
        o_s_axi_awready <= 1'b0;
      end
      if (i_s_axi_wvalid && o_s_axi_wready) begin
        w_held         <= 1'b1;
        wdata_reg      <= i_s_axi_wdata;
        o_s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        o_s_axi_bvalid <= 1'b1;
        o_s_axi_bresp  <= (awaddr_reg <= QRM_OFS_IRQ_MSK && awaddr_reg[1:0] == 2'h0
                           && awaddr_reg != QRM_OFS_STAT && awaddr_reg != QRM_OFS_RESULT)
                          ? QRM_RESP_OKAY : QRM_RESP_SLVERR;
      end
      if (o_s_axi_bvalid && i_s_axi_bready) begin
        o_s_axi_bvalid  <= 1'b0;
        aw_held         <= 1'b0;
        w_held          <= 1'b0;
        o_s_axi_awready <= 1'b1;
        o_s_axi_wready  <= 1'b1;
      end
    end
  end

  // Operand registers; header and destination frozen while a removal runs so the walk sees stable addresses, mask writable at any time
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hdr_reg     <= QRM_ZERO;
      dst_reg     <= QRM_ZERO;
      irq_msk_reg <= '0;
    end else if (wr_fire && i_s_axi_wstrb == 4'hF) begin
      if (awaddr_reg == QRM_OFS_HDR && st_reg == QRM_IDLE) hdr_reg <= wdata_reg;
      if (awaddr_reg == QRM_OFS_DST && st_reg == QRM_IDLE) dst_reg <= wdata_reg;
      if (awaddr_reg == QRM_OFS_IRQ_MSK) irq_msk_reg <= wdata_reg[QRM_IRQ_W-1:0];
    end
  end

  // Read channel; one read at a time, answered the cycle after the address
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_s_axi_arready <= 1'b1;
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_rdata   <= QRM_ZERO;
      o_s_axi_rresp   <= QRM_RESP_OKAY;
    end else if (i_s_axi_arvalid && o_s_axi_arready) begin
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid  <= 1'b1;
      o_s_axi_rresp   <= QRM_RESP_OKAY;
      unique case (i_s_axi_araddr)
        QRM_OFS_CTRL:    o_s_axi_rdata <= QRM_ZERO;
        QRM_OFS_HDR:     o_s_axi_rdata <= hdr_reg;
        QRM_OFS_DST:     o_s_axi_rdata <= dst_reg;
        QRM_OFS_STAT: begin
          o_s_axi_rdata                          <= QRM_ZERO;
          o_s_axi_rdata[QRM_ST_BUSY]             <= st_reg != QRM_IDLE;
          o_s_axi_rdata[QRM_ST_TAIL]             <= tail_reg;
          o_s_axi_rdata[QRM_ST_CC_LSB +: 4]      <= cc_reg;
          o_s_axi_rdata[QRM_ST_RSVD]             <= rsvd_reg;
          o_s_axi_rdata[QRM_ST_MMF]              <= mmf_reg;
        end
        QRM_OFS_RESULT:  o_s_axi_rdata <= result_reg;
        QRM_OFS_IRQ_ST:  o_s_axi_rdata <= {29'h0, irq_st_reg};
        QRM_OFS_IRQ_MSK: o_s_axi_rdata <= {29'h0, irq_msk_reg};
        default: begin
          o_s_axi_rdata <= QRM_ZERO;
          o_s_axi_rresp <= QRM_RESP_SLVERR;
        end
      endcase
    end else if (o_s_axi_rvalid && i_s_axi_rready) begin
      o_s_axi_rvalid  <= 1'b0;
      o_s_axi_arready <= 1'b1;
    end
  end

  // Next state; decisions on a memory state are taken at its acknowledge
  always_comb begin
    st_next  = st_reg;
    set_rsvd = 1'b0;
    set_mmf  = 1'b0;
    unique case (st_reg)
      QRM_IDLE: if (start) begin
        if (hdr_reg[2:0] != 3'h0 || hdr_reg == dst_reg) begin
          set_rsvd = 1'b1;
          st_next  = QRM_DONE;
        end else st_next = QRM_LRD;
      end
      QRM_LRD:  if (i_mem_ack) st_next = QRM_LWR;
      QRM_LWR:  if (i_mem_ack) begin
        if (tmp_reg[0]) st_next = QRM_DONE;
        else if (tmp_reg[2:1] != 2'h0) begin
          set_rsvd = 1'b1;
          st_next  = QRM_DONE;
        end else st_next = tail_reg ? QRM_RDB : (tmp_reg == QRM_ZERO ? QRM_PRB : QRM_RDE);
      end
      QRM_RDB:  if (i_mem_ack) begin
        if (i_mem_rdata[2:0] != 3'h0) begin
          set_rsvd = 1'b1;
          st_next  = QRM_REL;
        end else st_next = (tmp_reg == QRM_ZERO) ? QRM_PRB : QRM_RDE;
      end
      QRM_RDE:  if (i_mem_ack) begin
        if (i_mem_rdata[2:0] != 3'h0) begin
          set_rsvd = 1'b1;
          st_next  = QRM_REL;
        end else st_next = QRM_PRB;
      end
      QRM_PRB, QRM_PRS: if (i_mem_ack) begin
        if (i_mem_deny) begin
          set_mmf = 1'b1;
          st_next = QRM_REL;
        end else if (st_reg == QRM_PRS) st_next = QRM_WLNK;
        else st_next = (tmp_reg == QRM_ZERO) ? QRM_WDST : QRM_PRS;
      end
      QRM_WLNK: if (i_mem_ack) st_next = QRM_WDST;
      QRM_WDST: if (i_mem_ack) st_next = tail_reg ? QRM_WBLK : QRM_WHDR;
      QRM_WBLK: if (i_mem_ack) st_next = QRM_WHDR;
      QRM_WHDR, QRM_REL: if (i_mem_ack) st_next = QRM_DONE;
      QRM_DONE: st_next = QRM_IDLE;
      default:  st_next = QRM_IDLE;
    endcase
  end

  // Memory request for the current state
  always_comb begin
    req_next       = '0;
    req_next.valid = 1'b1;
    unique case (st_reg)
      QRM_LRD: begin
        req_next.lock = 1'b1;
        req_next.addr = hdr_reg;
      end
      QRM_LWR: begin
        req_next.lock  = 1'b1;
        req_next.write = 1'b1;
        req_next.addr  = hdr_reg;
        req_next.wdata = (tmp_reg[0] || tmp_reg[2:1] != 2'h0)
                         ? tmp_reg : (tmp_reg | QRM_SEC_LOCK);
      end
      QRM_RDB:  req_next.addr = hdr_reg + QRM_BLINK_OFS;
      QRM_RDE:  req_next.addr = tail_reg ? ent + QRM_BLINK_OFS : ent;
      QRM_PRB: begin
        req_next.probe = 1'b1;
        req_next.write = 1'b1;
        req_next.addr  = dst_reg;
      end
      QRM_PRS: begin
        req_next.probe = 1'b1;
        req_next.write = 1'b1;
        req_next.addr  = tail_reg ? nbr : nbr + QRM_BLINK_OFS;
      end
      QRM_WLNK: begin
        req_next.write = 1'b1;
        req_next.addr  = tail_reg ? nbr : nbr + QRM_BLINK_OFS;
        req_next.wdata = hdr_reg - nbr;
      end
      QRM_WDST: begin
        req_next.write = 1'b1;
        req_next.addr  = dst_reg;
        req_next.wdata = ent;
      end
      QRM_WBLK: begin
        req_next.write = 1'b1;
        req_next.addr  = hdr_reg + QRM_BLINK_OFS;
        req_next.wdata = new_link;
      end
      QRM_WHDR: begin
        req_next.write = 1'b1;
        req_next.addr  = hdr_reg;
        // Tail with the header as predecessor: the link write already zeroed it
        req_next.wdata = tail_reg ? ((nbr == hdr_reg) ? QRM_ZERO : tmp_reg)
                                  : new_link;
      end
      QRM_REL: begin
        req_next.write = 1'b1;
        req_next.addr  = hdr_reg;
        req_next.wdata = tmp_reg;
      end
      default: req_next = '0;
    endcase
  end

  // Sequencer; each memory state issues once, then waits for its acknowledge
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg    <= QRM_IDLE;
      o_mem     <= '0;
      tail_reg  <= 1'b0;
      tmp_reg   <= QRM_ZERO;
      blink_reg <= QRM_ZERO;
      link_reg  <= QRM_ZERO;
    end else begin
      if (start) begin
        tail_reg  <= wr_opc == QRM_OPC_TAIL;
        blink_reg <= QRM_ZERO;
        link_reg  <= QRM_ZERO;
      end
      if (st_reg == QRM_IDLE || st_reg == QRM_DONE) st_reg <= st_next;
      else if (!o_mem.valid) o_mem <= req_next;
      else if (i_mem_ack) begin
        o_mem.valid <= 1'b0;
        st_reg      <= st_next;
        if (st_reg == QRM_LRD) tmp_reg <= i_mem_rdata;
        if (st_reg == QRM_RDB) blink_reg <= i_mem_rdata;
        if (st_reg == QRM_RDE) link_reg <= i_mem_rdata;
      end
    end
  end

  // Outcome: fault flags, result and condition codes
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rsvd_reg   <= 1'b0;
      mmf_reg    <= 1'b0;
      cc_reg     <= '0;
      result_reg <= QRM_ZERO;
    end else begin
      if (start) begin
        rsvd_reg <= 1'b0;
        mmf_reg  <= 1'b0;
      end
      if (set_rsvd) rsvd_reg <= 1'b1;
      if (set_mmf) mmf_reg <= 1'b1;
      if (st_reg == QRM_WDST && i_mem_ack) result_reg <= ent;
      // Faults leave the codes alone; the instruction is backed up
      if (st_reg == QRM_DONE && !rsvd_reg && !mmf_reg) begin
        if (tmp_reg[0]) cc_reg <= '{n: 1'b0, z: 1'b0, v: 1'b1, c: 1'b1};
        else cc_reg <= '{n: 1'b0, z: new_link == QRM_ZERO,
                         v: tmp_reg == QRM_ZERO, c: 1'b0};
      end
    end
  end

  // Interrupt status: set wins over a same-cycle write-one clear
  assign irq_ev = (st_reg == QRM_DONE) ? {mmf_reg, rsvd_reg, 1'b1} : '0;
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_st_reg  <= '0;
      o_irq       <= 1'b0;
      o_intr_hold <= 1'b0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~((wr_fire && awaddr_reg == QRM_OFS_IRQ_ST)
                    ? wdata_reg[QRM_IRQ_W-1:0] : '0)) | irq_ev;
      o_irq      <= |(irq_st_reg & irq_msk_reg);
      // Held from start to completion so the update is never split
      o_intr_hold <= start || (st_reg != QRM_IDLE && st_reg != QRM_DONE);
    end
  end

  // Checks
  chk_lock_header: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_mem.valid && o_mem.lock |-> o_mem.addr == hdr_reg && hdr_reg[2:0] == 3'h0)
    else $error("locked access not at aligned header");
  chk_busy_back: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    st_reg == QRM_LWR && o_mem.valid && tmp_reg[0] && i_mem_ack
    |-> o_mem.wdata == tmp_reg ##1 st_reg == QRM_DONE ##1 cc_reg == 4'h3)
    else $error("busy header not written back unchanged");
  chk_set_second: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    st_reg == QRM_LWR && o_mem.valid && tmp_reg[2:0] == 3'h0
    |-> o_mem.wdata == (tmp_reg | QRM_SEC_LOCK) && o_mem.lock && o_mem.write)
    else $error("secondary lock not set on write back");
  chk_deny_release: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    o_mem.valid && o_mem.probe && i_mem_ack && i_mem_deny
    |=> st_reg == QRM_REL ##1 (o_mem.valid && o_mem.wdata == tmp_reg))
    else $error("denied probe not followed by release");
  chk_dst_first: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    st_reg == QRM_WDST && i_mem_ack |=> st_reg == QRM_WHDR || st_reg == QRM_WBLK)
    else $error("header released before destination write");
  chk_head_entry: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    st_reg == QRM_RDE && o_mem.valid && !tail_reg |-> o_mem.addr == hdr_reg + tmp_reg)
    else $error("head removal reads wrong entry");
  chk_tail_entry: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    st_reg == QRM_RDE && o_mem.valid && tail_reg
    |-> o_mem.addr == hdr_reg + blink_reg + QRM_BLINK_OFS)
    else $error("tail removal reads wrong entry");
  chk_rsvd_align: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    start && hdr_reg[2:0] != 3'h0 |=> st_reg == QRM_DONE && !o_mem.valid ##1 rsvd_reg)
    else $error("misaligned header not refused");
  chk_irq_hold: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    st_reg != QRM_IDLE && st_reg != QRM_DONE |=> o_intr_hold)
    else $error("interrupts not held during update");
  chk_v_empty: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    st_reg == QRM_DONE && !rsvd_reg && !mmf_reg |=> cc_reg.v == (tmp_reg == QRM_ZERO
    || tmp_reg[0]) && !cc_reg.n)
    else $error("V does not match removal outcome");

endmodule : qrm_engine
`default_nettype wire

// ### pkg/qrm_pkg.sv
// Constants, states and carrier types for the locked queue removal engine
package qrm_pkg;
  // Register bus geometry and answers
  localparam int          QRM_AW          = 8;
  localparam logic [1:0]  QRM_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  QRM_RESP_SLVERR = 2'h2;
  // Register byte offsets
  localparam logic [7:0]  QRM_OFS_CTRL    = 8'h00;
  localparam logic [7:0]  QRM_OFS_HDR     = 8'h04;
  localparam logic [7:0]  QRM_OFS_DST     = 8'h08;
  localparam logic [7:0]  QRM_OFS_STAT    = 8'h0C;
  localparam logic [7:0]  QRM_OFS_RESULT  = 8'h10;
  localparam logic [7:0]  QRM_OFS_IRQ_ST  = 8'h14;
  localparam logic [7:0]  QRM_OFS_IRQ_MSK = 8'h18;
  // Control fields: go bit and opcode byte
  localparam int          QRM_CTRL_GO     = 0;
  localparam int          QRM_OPC_LSB     = 8;
  localparam logic [7:0]  QRM_OPC_HEAD    = 8'h5E;
  localparam logic [7:0]  QRM_OPC_TAIL    = 8'h5F;
  // Status fields
  localparam int          QRM_ST_BUSY     = 0;
  localparam int          QRM_ST_TAIL     = 1;
  localparam int          QRM_ST_CC_LSB   = 4;
  localparam int          QRM_ST_RSVD     = 8;
  localparam int          QRM_ST_MMF      = 9;
  // Interrupt status and mask layout
  localparam int          QRM_IRQ_W       = 3;
  localparam int          QRM_IRQ_DONE    = 0;
  localparam int          QRM_IRQ_RSVD    = 1;
  localparam int          QRM_IRQ_MMF     = 2;
  // Queue layout
  localparam logic [31:0] QRM_BLINK_OFS   = 32'h0000_0004;
  localparam logic [31:0] QRM_ZERO        = 32'h0000_0000;
  localparam logic [31:0] QRM_SEC_LOCK    = 32'h0000_0001;

  // Sequencer states
  typedef enum logic [3:0] {
    QRM_IDLE = 4'h0, QRM_LRD  = 4'h1, QRM_LWR  = 4'h2, QRM_RDB  = 4'h3,
    QRM_RDE  = 4'h4, QRM_PRB  = 4'h5, QRM_PRS  = 4'h6, QRM_WLNK = 4'h7,
    QRM_WDST = 4'h8, QRM_WBLK = 4'h9, QRM_WHDR = 4'hA, QRM_REL  = 4'hB,
    QRM_DONE = 4'hC
  } qrm_state_t;

  // One memory request to the shared memory
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        lock;
    logic        probe;
    logic [31:0] addr;
    logic [31:0] wdata;
  } qrm_mem_req_t;

  // Condition codes
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } qrm_cc_t;
endpackage : qrm_pkg

// ### sim/qrm_engine_bench.sv
// Self-checking bench for the locked queue removal engine
`timescale 1ns/1ps
`default_nettype none
module qrm_engine_bench
  import qrm_pkg::*;
;
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] m;
    logic [1:0]  r;
  } qrm_exp_t;
  logic         core_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, mem_ack, mem_deny, intr_hold, irq;
  logic [7:0]   awaddr, araddr;
  logic [31:0]  wdata, rdata, mem_rdata, deny_addr, cur_h, ent;
  logic [1:0]   bresp, rresp;
  logic [3:0]   mem_delay;
  qrm_mem_req_t mreq;
  qrm_exp_t     exp_r[$];
  qrm_exp_t     ex;
  logic [1:0]   exp_b[$];
  int           err_count, check_count, cycles;
  int unsigned  seed_val;

  qrm_engine i_dut (.i_core_clk(core_clk), .i_nrst(nrst), .i_s_axi_awvalid(awvalid),
    .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr), .i_s_axi_wvalid(wvalid),
    .o_s_axi_wready(wready), .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF),
    .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready), .i_s_axi_araddr(araddr),
    .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready), .o_s_axi_rdata(rdata),
    .o_s_axi_rresp(rresp), .o_mem(mreq), .i_mem_ack(mem_ack), .i_mem_rdata(mem_rdata),
    .i_mem_deny(mem_deny), .o_intr_hold(intr_hold), .o_irq(irq));
  qrm_mem_model i_mem_model (.i_core_clk(core_clk), .i_nrst(nrst), .i_mem(mreq),
    .o_ack(mem_ack), .o_rdata(mem_rdata), .o_deny(mem_deny), .i_delay(mem_delay),
    .i_deny_addr(deny_addr));

  // Free running core clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ap, wp;
    exp_b.push_back(r);
    @(posedge core_clk);
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    ap = 1'b1;
    wp = 1'b1;
    while (ap || wp) begin
      @(posedge core_clk);
      if (ap && awready === 1'b1) begin ap = 1'b0; awvalid <= 1'b0; end
      if (wp && wready === 1'b1) begin wp = 1'b0; wvalid <= 1'b0; end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] r);
    exp_r.push_back('{d: d, m: m, r: r});
    @(posedge core_clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : axi_rd

  task automatic irq_chk(input logic [7:0] a, input logic [31:0] d, input logic x);
    axi_wr(a, d, QRM_RESP_OKAY);
    repeat (3) @(posedge core_clk);
    chk("interrupt line", {31'h0, irq}, {31'h0, x});
  endtask : irq_chk

  // Single entry queue at h holding e (e equal h gives an empty queue)
  // tw bits 1:0 mark the header word, bit 2 spoils the entry's forward link
  task automatic scen(input logic [7:0] opc, input logic [31:0] h, e, d, tw,
                      input logic keep, dn, input logic [31:0] st, msk);
    logic [31:0] ie;
    i_mem_model.mem[e[7:2]] = (h - e) | (tw & 32'h4);
    i_mem_model.mem[e[7:2] + 6'h1] = h - e;
    i_mem_model.mem[h[7:2]] = (e - h) | (tw & 32'h3);
    i_mem_model.mem[h[7:2] + 6'h1] = e - h;
    if (d != h) i_mem_model.mem[d[7:2]] = 32'h5A5A_5A5A;
    cur_h <= h;
    deny_addr <= dn ? d : 32'hFFFF_FFFF;
    mem_delay <= 4'($urandom % 4);
    axi_wr(QRM_OFS_HDR, h, QRM_RESP_OKAY);
    axi_wr(QRM_OFS_DST, d, QRM_RESP_OKAY);
    axi_wr(QRM_OFS_CTRL, {16'h0000, opc, 8'h01}, QRM_RESP_OKAY);
    while (irq !== 1'b1) @(posedge core_clk);
    ie = st[8] ? 32'h2 : (st[9] ? 32'h4 : 32'h1);
    axi_rd(QRM_OFS_STAT, st, msk, QRM_RESP_OKAY);
    axi_rd(QRM_OFS_IRQ_ST, ie, ie, QRM_RESP_OKAY);
    if (!keep && e != h) axi_rd(QRM_OFS_RESULT, e, 32'hFFFF_FFFF, QRM_RESP_OKAY);
    chk("header link", i_mem_model.mem[h[7:2]], keep ? (e - h) | (tw & 32'h3) : 32'h0);
    chk("lock window", {31'h0, i_mem_model.locked_reg}, 32'h0);
    chk("header back", i_mem_model.mem[h[7:2] + 6'h1], keep ? e - h : 32'h0);
    if (d != h) chk("dest", i_mem_model.mem[d[7:2]], keep ? 32'h5A5A_5A5A : e);
    // Mask hides the pending event, unmask shows it, clearing drops it
    irq_chk(QRM_OFS_IRQ_MSK, 32'h0, 1'b0);
    irq_chk(QRM_OFS_IRQ_MSK, 32'h7, 1'b1);
    irq_chk(QRM_OFS_IRQ_ST, 32'h7, 1'b0);
    $display("test done opcode %h header %h", opc, h);
  endtask : scen

  // Result checker: oldest note against each answer
  always @(posedge core_clk) begin
    if (bvalid && bready && exp_b.size() > 0)
      chk("write response", {30'h0, bresp}, {30'h0, exp_b.pop_front()});
    if (rvalid && rready && exp_r.size() > 0) begin
      ex = exp_r.pop_front();
      chk("read data", rdata & ex.m, ex.d & ex.m);
      chk("read response", {30'h0, rresp}, {30'h0, ex.r});
    end
    if (mreq.valid) chk("interrupt hold", {31'h0, intr_hold}, 32'h1);
    if (mreq.valid && mreq.lock && !mreq.write) chk("locked read", mreq.addr, cur_h);
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // Main sequence
  initial begin
    nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0;
    deny_addr = 32'hFFFF_FFFF; cur_h = 32'h0; mem_delay = 4'h0;
    seed_val = $urandom(82);
    ent = 32'h0000_0080 + 32'(($urandom % 8) * 8);
    repeat (16) @(posedge core_clk);
    nrst <= 1'b1;
    axi_rd(QRM_OFS_STAT, 32'h0, 32'hFFFF_FFFF, QRM_RESP_OKAY);
    axi_rd(QRM_OFS_IRQ_MSK, 32'h0, 32'hFFFF_FFFF, QRM_RESP_OKAY);
    axi_rd(8'h1C, 32'h0, 32'hFFFF_FFFF, QRM_RESP_SLVERR);
    axi_wr(QRM_OFS_RESULT, 32'h1234_5678, QRM_RESP_SLVERR);
    axi_wr(QRM_OFS_IRQ_MSK, 32'h7, QRM_RESP_OKAY);
    axi_rd(QRM_OFS_IRQ_MSK, 32'h7, 32'hFFFF_FFFF, QRM_RESP_OKAY);
    axi_rd(QRM_OFS_CTRL, 32'h0, 32'hFFFF_FFFF, QRM_RESP_OKAY);
    $display("test done registers");
    scen(QRM_OPC_HEAD, 32'h40, ent, 32'hE0, 32'h0, 1'b0, 1'b0, 32'h040, 32'h3F3);
    scen(QRM_OPC_TAIL, 32'h40, ent, 32'hE0, 32'h0, 1'b0, 1'b0, 32'h042, 32'h3F3);
    scen(QRM_OPC_HEAD, 32'h40, 32'h40, 32'hE0, 32'h0, 1'b0, 1'b0, 32'h060, 32'h3F3);
    scen(QRM_OPC_TAIL, 32'h40, 32'h40, 32'hE0, 32'h0, 1'b0, 1'b0, 32'h062, 32'h3F3);
    scen(QRM_OPC_HEAD, 32'h40, ent, 32'hE0, 32'h1, 1'b1, 1'b0, 32'h030, 32'h3F3);
    scen(QRM_OPC_TAIL, 32'h40, ent, 32'hE0, 32'h1, 1'b1, 1'b0, 32'h032, 32'h3F3);
    scen(QRM_OPC_HEAD, 32'h40, ent, 32'h40, 32'h0, 1'b1, 1'b0, 32'h100, 32'h100);
    scen(QRM_OPC_HEAD, 32'h40, ent, 32'hE0, 32'h2, 1'b1, 1'b0, 32'h100, 32'h100);
    scen(QRM_OPC_HEAD, 32'h40, ent, 32'hE0, 32'h4, 1'b1, 1'b0, 32'h100, 32'h100);
    scen(QRM_OPC_TAIL, 32'h44, ent, 32'hE0, 32'h0, 1'b1, 1'b0, 32'h100, 32'h100);
    scen(QRM_OPC_TAIL, 32'h40, ent, 32'hE0, 32'h0, 1'b1, 1'b1, 32'h200, 32'h200);
    wrap_up();
  end
endmodule : qrm_engine_bench
`default_nettype wire

// ### sim/qrm_mem_model.sv
// Shared memory model answering the removal engine's requests
`timescale 1ns/1ps
`default_nettype none
module qrm_mem_model
  import qrm_pkg::*;
(
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_nrst,
  // Request side
  input  wire qrm_mem_req_t i_mem,
  output logic              o_ack,
  output logic [31:0]       o_rdata,
  output logic              o_deny,
  // Bench controls
  input  wire logic [3:0]   i_delay,
  input  wire logic [31:0]  i_deny_addr
);
  logic [31:0] mem [0:63];
  logic [3:0]  wait_reg;
  logic        locked_reg;

  // Answer after i_delay idle cycles, so both prompt and slow replies occur
  always @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ack      <= 1'b0;
      o_rdata    <= 32'h0000_0000;
      o_deny     <= 1'b0;
      wait_reg   <= 4'h0;
      locked_reg <= 1'b0;
    end else if (o_ack || !i_mem.valid) begin
      // Ack drops; data and deny lines toggle each cycle with no request waiting rather than hold the last answer
      o_ack    <= 1'b0;
      o_rdata  <= ~o_rdata;
      o_deny   <= ~o_deny;
      wait_reg <= 4'h0;
    end else if (wait_reg < i_delay) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      o_ack   <= 1'b1;
      o_deny  <= i_mem.probe && (i_mem.addr == i_deny_addr);
      o_rdata <= mem[i_mem.addr[7:2]];
      // Probes only check access, nothing is stored
      if (i_mem.write && !i_mem.probe)
        mem[i_mem.addr[7:2]] <= i_mem.wdata;
      // Locked window; a second port would be held off while set
      if (i_mem.lock)
        locked_reg <= !i_mem.write;
    end
  end
endmodule : qrm_mem_model
`default_nettype wire
